/* include/ptpevt_map.vh */
// register map, field positions and reset values of the ptp event status block
// included by the design file; definitions only
`ifndef PTPEVT_MAP_VH
`define PTPEVT_MAP_VH

`define PTPEVT_ADDR_STATUS     12'h108
`define PTPEVT_ADDR_ENABLE     12'h10c
`define PTPEVT_ADDR_ACTION     12'h100
`define PTPEVT_ADDR_SYSIRQ     12'h180
`define PTPEVT_ADDR_CAPINFO    12'h184
`define PTPEVT_ADDR_CLK_SEC    12'h110
`define PTPEVT_ADDR_CLK_NS     12'h114
`define PTPEVT_ADDR_TGT_BASE   12'h140
`define PTPEVT_ADDR_TGT_A_SEC  12'h140
`define PTPEVT_ADDR_TGT_A_NS   12'h144
`define PTPEVT_ADDR_STEP_A_SEC 12'h148
`define PTPEVT_ADDR_STEP_A_NS  12'h14c
`define PTPEVT_ADDR_TGT_B_SEC  12'h150
`define PTPEVT_ADDR_TGT_B_NS   12'h154
`define PTPEVT_ADDR_STEP_B_SEC 12'h158
`define PTPEVT_ADDR_STEP_B_NS  12'h15c
`define PTPEVT_ADDR_W          12
`define PTPEVT_SLOT_SEL        2:0

`define PTPEVT_ST_FALL         31:24
`define PTPEVT_ST_RISE         23:16
`define PTPEVT_ST_EGRESS       12
`define PTPEVT_ST_INGRESS      8
`define PTPEVT_ST_TMR_B        1
`define PTPEVT_ST_TMR_A        0
`define PTPEVT_ST_MASK         32'hffff1103

`define PTPEVT_ACT_RELOAD_A    0
`define PTPEVT_ACT_RELOAD_B    1
`define PTPEVT_ACT_CLR_A_SEL   10:8
`define PTPEVT_ACT_CLR_A_EN    11
`define PTPEVT_ACT_CLR_B_SEL   14:12
`define PTPEVT_ACT_CLR_B_EN    15
`define PTPEVT_ACT_MASK        32'h0000ff03

`define PTPEVT_SYS_SUMMARY     0
`define PTPEVT_CAP_EGRESS      6:4
`define PTPEVT_CAP_INGRESS     2:0
`define PTPEVT_STAMP_MAX       3'h4
`define PTPEVT_NS_PER_SEC      30'h3b9aca00
`define PTPEVT_RESET_WORD      32'h00000000

`endif

/* verilog/ptpevt_status.v */
// ptp event status block: sticky event flags, enables, summary event, target reload/add
// assumes an apb master on mclk, event inputs synchronous one-cycle pulses or levels
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "ptpevt_map.vh"

// Behaviour
// - channel a action bit: 0 add, 1 reload
// - channel b action bit: set reload, clear add
// - add mode adds step to target time
// - write one clears status bit, zero keeps
// - status records events regardless of enables
// - enabled status bits or into summary event
// - system irq needs summary enable too
// - falling capture sets bits 31:24
// - rising capture sets bits 23:16
// - manual capture sets edge bits too
// - egress stamp sets bit 12
// - egress count up to four, three bits
// - ingress stamp sets bit 8
// - ingress count up to four, three bits
// - clock reaching target b sets bit 1
// - clock reaching target a sets bit 0
// - gpio edge clears timer bit when enabled
// - per timer clear enable and gpio select
// - enable register mirrors status positions
module ptpevt_status #(
    parameter NGPIO = 8
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [NGPIO-1:0] capture_gpio,
    input  wire [NGPIO-1:0] gpio_polarity,
    input  wire [NGPIO-1:0] manual_capture,
    input  wire        egress_stamp_stored,
    input  wire        egress_stamp_read,
    input  wire        ingress_stamp_stored,
    input  wire        ingress_stamp_read,
    input  wire [31:0] clock_seconds,
    input  wire [29:0] clock_nanoseconds,
    output wire        time_unit_summary_event,
    output wire        system_irq,
    output reg  [31:0] tgt_a_seconds_q,
    output reg  [29:0] tgt_a_nanoseconds_q,
    output reg  [31:0] tgt_b_seconds_q,
    output reg  [29:0] tgt_b_nanoseconds_q
);

    reg  [31:0]      status_q;
    reg  [31:0]      status_d;
    reg  [31:0]      enable_q;
    reg  [31:0]      action_q;
    reg              sum_en_q;
    reg  [2:0]       egress_stamp_count_q;
    reg  [2:0]       ingress_stamp_count_q;
    reg  [NGPIO-1:0] gpio_q;
    reg  [NGPIO-1:0] gpio_qq;
    reg  [31:0]      step_a_sec_q;
    reg  [29:0]      step_a_ns_q;
    reg  [31:0]      step_b_sec_q;
    reg  [29:0]      step_b_ns_q;
    reg              hit_a_q;
    reg              hit_b_q;
    wire             wr_en;
    wire             rd_en;
    wire [NGPIO-1:0] gpio_rise;
    wire [NGPIO-1:0] gpio_fall;
    wire [NGPIO-1:0] act_lvl;
    wire [NGPIO-1:0] act_edge;
    wire             reach_a;
    wire             reach_b;
    wire             clr_gpio_a;
    wire             clr_gpio_b;
    wire [31:0]      evt_set;
    wire [31:0]      w1c;
    wire [31:0]      sys_word;
    wire [31:0]      capinfo_word;

    // time at or beyond target
    function reached;
        input [31:0] cs;
        input [29:0] cn;
        input [31:0] ts;
        input [29:0] tn;
        begin
            reached = (cs > ts) || ((cs == ts) && (cn >= tn));
        end
    endfunction

    // register decode of the low address bits
    function hit_addr;
        input [31:0] a;
        input [11:0] off;
        begin
            hit_addr = (a[`PTPEVT_ADDR_W-1:0] == off);
        end
    endfunction

    // stamp count step: saturate at four, floor at zero, store and pop cancel
    function [2:0] next_count;
        input [2:0] cnt;
        input       stored;
        input       popped;
        begin
            if (stored && !popped && cnt != `PTPEVT_STAMP_MAX)
                next_count = cnt + 3'h1;
            else if (popped && !stored && cnt != 3'h0)
                next_count = cnt - 3'h1;
            else
                next_count = cnt;
        end
    endfunction

    // next target: add step with ns carry, or reload
    // both ns terms stay below one second, so a single carry is enough
    function [61:0] next_target;
        input        reload;
        input [31:0] ts;
        input [29:0] tn;
        input [31:0] ss;
        input [29:0] sn;
        reg   [30:0] nsum;
        begin
            nsum = {1'b0, tn} + {1'b0, sn};
            if (reload)
                next_target = {ss, sn};
            else if (nsum >= {1'b0, `PTPEVT_NS_PER_SEC})
                next_target = {ts + ss + 32'h00000001,
                               nsum[29:0] - `PTPEVT_NS_PER_SEC};
            else
                next_target = {ts + ss, nsum[29:0]};
        end
    endfunction

    // apb: zero wait state, every word answers, unmapped reads zero
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~pwrite;

    // two stage capture of gpio inputs, edges between the two stages
    always @(posedge mclk)
    begin
        if (rst)
        begin
            gpio_q  <= {NGPIO{1'b0}};
            gpio_qq <= {NGPIO{1'b0}};
        end
        else
        begin
            gpio_q  <= capture_gpio;
            gpio_qq <= gpio_q;
        end
    end

    // edge detection, pulses shorter than one mclk may be missed
    assign gpio_rise = gpio_q & ~gpio_qq;
    assign gpio_fall = ~gpio_q & gpio_qq;
    assign act_lvl   = gpio_q ^ ~gpio_polarity;
    assign act_edge  = act_lvl & ~(gpio_qq ^ ~gpio_polarity);

    // gpio clear of timer flags through selected input
    assign clr_gpio_a = action_q[`PTPEVT_ACT_CLR_A_EN] &
                        act_edge[action_q[`PTPEVT_ACT_CLR_A_SEL]];
    assign clr_gpio_b = action_q[`PTPEVT_ACT_CLR_B_EN] &
                        act_edge[action_q[`PTPEVT_ACT_CLR_B_SEL]];

    // compare, pulse on the first cycle the target is reached
    // hit flag rearms only after the compare drops, so no event repeats
    assign reach_a = reached(clock_seconds, clock_nanoseconds,
                             tgt_a_seconds_q, tgt_a_nanoseconds_q);
    assign reach_b = reached(clock_seconds, clock_nanoseconds,
                             tgt_b_seconds_q, tgt_b_nanoseconds_q);

    // event set vector
    assign evt_set[`PTPEVT_ST_FALL]    = gpio_fall | manual_capture;
    assign evt_set[`PTPEVT_ST_RISE]    = gpio_rise | manual_capture;
    assign evt_set[15:13]              = 3'h0;
    assign evt_set[`PTPEVT_ST_EGRESS]  = egress_stamp_stored;
    assign evt_set[11:9]               = 3'h0;
    assign evt_set[`PTPEVT_ST_INGRESS] = ingress_stamp_stored;
    assign evt_set[7:2]                = 6'h00;
    assign evt_set[`PTPEVT_ST_TMR_B]   = reach_b & ~hit_b_q;
    assign evt_set[`PTPEVT_ST_TMR_A]   = reach_a & ~hit_a_q;

    // software and gpio clears
    assign w1c = ((wr_en && paddr[`PTPEVT_ADDR_W-1:0] == `PTPEVT_ADDR_STATUS) ?
                  pwdata : 32'h00000000)
               | {30'h00000000, clr_gpio_b, clr_gpio_a};

    // next status: clear then set, so a new event wins
    always @*
    begin
        status_d = ((status_q & ~w1c) | evt_set) & `PTPEVT_ST_MASK;
    end

    // status flags
    always @(posedge mclk)
    begin
        if (rst)
        begin
            status_q <= `PTPEVT_RESET_WORD;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    // software writable enable, action and summary enable registers
    always @(posedge mclk)
    begin
        if (rst)
        begin
            enable_q <= `PTPEVT_RESET_WORD;
            action_q <= `PTPEVT_RESET_WORD;
            sum_en_q <= 1'b0;
        end
        else if (wr_en)
        begin
            case (paddr[`PTPEVT_ADDR_W-1:0])
                `PTPEVT_ADDR_ENABLE: enable_q <= pwdata & `PTPEVT_ST_MASK;
                `PTPEVT_ADDR_ACTION: action_q <= pwdata & `PTPEVT_ACT_MASK;
                `PTPEVT_ADDR_SYSIRQ: sum_en_q <= pwdata[`PTPEVT_SYS_SUMMARY];
                default:             sum_en_q <= sum_en_q;
            endcase
        end
    end

    // software writable step registers of both channels
    always @(posedge mclk)
    begin
        if (rst)
        begin
            step_a_sec_q <= 32'h00000000;
            step_a_ns_q  <= 30'h00000000;
            step_b_sec_q <= 32'h00000000;
            step_b_ns_q  <= 30'h00000000;
        end
        else if (wr_en)
        begin
            case (paddr[`PTPEVT_ADDR_W-1:0])
                `PTPEVT_ADDR_STEP_A_SEC: step_a_sec_q <= pwdata;
                `PTPEVT_ADDR_STEP_A_NS:  step_a_ns_q  <= pwdata[29:0];
                `PTPEVT_ADDR_STEP_B_SEC: step_b_sec_q <= pwdata;
                `PTPEVT_ADDR_STEP_B_NS:  step_b_ns_q  <= pwdata[29:0];
                default:                 step_a_sec_q <= step_a_sec_q;
            endcase
        end
    end

    // target a: software load wins, else advance on compare event
    always @(posedge mclk)
    begin
        if (rst)
        begin
            tgt_a_seconds_q     <= 32'h00000000;
            tgt_a_nanoseconds_q <= 30'h00000000;
            hit_a_q             <= 1'b0;
        end
        else
        begin
            hit_a_q <= reach_a;
            if (wr_en && hit_addr(paddr, `PTPEVT_ADDR_TGT_A_SEC))
            begin
                tgt_a_seconds_q <= pwdata;
            end
            else if (wr_en && hit_addr(paddr, `PTPEVT_ADDR_TGT_A_NS))
            begin
                tgt_a_nanoseconds_q <= pwdata[29:0];
            end
            else if (evt_set[`PTPEVT_ST_TMR_A])
            begin
                {tgt_a_seconds_q, tgt_a_nanoseconds_q} <= next_target(
                    action_q[`PTPEVT_ACT_RELOAD_A], tgt_a_seconds_q,
                    tgt_a_nanoseconds_q, step_a_sec_q, step_a_ns_q);
            end
        end
    end

    // target b: software load wins, else advance on compare event
    always @(posedge mclk)
    begin
        if (rst)
        begin
            tgt_b_seconds_q     <= 32'h00000000;
            tgt_b_nanoseconds_q <= 30'h00000000;
            hit_b_q             <= 1'b0;
        end
        else
        begin
            hit_b_q <= reach_b;
            if (wr_en && hit_addr(paddr, `PTPEVT_ADDR_TGT_B_SEC))
            begin
                tgt_b_seconds_q <= pwdata;
            end
            else if (wr_en && hit_addr(paddr, `PTPEVT_ADDR_TGT_B_NS))
            begin
                tgt_b_nanoseconds_q <= pwdata[29:0];
            end
            else if (evt_set[`PTPEVT_ST_TMR_B])
            begin
                {tgt_b_seconds_q, tgt_b_nanoseconds_q} <= next_target(
                    action_q[`PTPEVT_ACT_RELOAD_B], tgt_b_seconds_q,
                    tgt_b_nanoseconds_q, step_b_sec_q, step_b_ns_q);
            end
        end
    end

    // stamp counters, saturate at four, decrement on reader pop
    always @(posedge mclk)
    begin
        if (rst)
        begin
            egress_stamp_count_q  <= 3'h0;
            ingress_stamp_count_q <= 3'h0;
        end
        else
        begin
            egress_stamp_count_q  <= next_count(egress_stamp_count_q,
                                                egress_stamp_stored, egress_stamp_read);
            ingress_stamp_count_q <= next_count(ingress_stamp_count_q,
                                                ingress_stamp_stored, ingress_stamp_read);
        end
    end

    // summary event and system interrupt
    assign time_unit_summary_event = |(status_q & enable_q);
    assign system_irq = time_unit_summary_event & sum_en_q;

    // packed read words of the small registers
    assign sys_word     = {30'h00000000, time_unit_summary_event, sum_en_q};
    assign capinfo_word = {25'h0000000, egress_stamp_count_q, 1'b0, ingress_stamp_count_q};

    // read data, registered on the setup cycle
    always @(posedge mclk)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (rd_en && !penable)
        begin
            case (paddr[`PTPEVT_ADDR_W-1:0])
                `PTPEVT_ADDR_STATUS:  prdata <= status_q;
                `PTPEVT_ADDR_ENABLE:  prdata <= enable_q;
                `PTPEVT_ADDR_ACTION:  prdata <= action_q;
                `PTPEVT_ADDR_SYSIRQ:  prdata <= sys_word;
                `PTPEVT_ADDR_CAPINFO: prdata <= capinfo_word;
                `PTPEVT_ADDR_TGT_A_SEC:  prdata <= tgt_a_seconds_q;
                `PTPEVT_ADDR_TGT_A_NS:   prdata <= {2'h0, tgt_a_nanoseconds_q};
                `PTPEVT_ADDR_STEP_A_SEC: prdata <= step_a_sec_q;
                `PTPEVT_ADDR_STEP_A_NS:  prdata <= {2'h0, step_a_ns_q};
                `PTPEVT_ADDR_TGT_B_SEC:  prdata <= tgt_b_seconds_q;
                `PTPEVT_ADDR_TGT_B_NS:   prdata <= {2'h0, tgt_b_nanoseconds_q};
                `PTPEVT_ADDR_STEP_B_SEC: prdata <= step_b_sec_q;
                `PTPEVT_ADDR_STEP_B_NS:  prdata <= {2'h0, step_b_ns_q};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // ptpevt_status

/* bench/ptpevt_status_props.sv */
// checker for the ptp event status block: summary, irq, bus answer, target hold
// bound to ptpevt_status from the bench top; sees its ports only
`timescale 1ns/1ps
module ptpevt_status_props #(
    parameter NGPIO = 8
) (
    input wire             mclk,
    input wire             rst,
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire [31:0]      paddr,
    input wire [31:0]      pwdata,
    input wire [31:0]      prdata,
    input wire             pready,
    input wire             pslverr,
    input wire [NGPIO-1:0] manual_capture,
    input wire             egress_stamp_stored,
    input wire             ingress_stamp_stored,
    input wire [31:0]      clock_seconds,
    input wire             time_unit_summary_event,
    input wire             system_irq,
    input wire [31:0]      tgt_a_seconds_q,
    input wire [31:0]      tgt_b_seconds_q
);
    wire        wr_on = psel & penable & pwrite;
    wire        wr_en = wr_on & (paddr[11:0] == 12'h10c);
    reg  [31:0] en_q;
    reg         sysen_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // shadow of the enable bits as written over the bus
    always @(posedge mclk)
    begin
        if (rst)
        begin
            en_q    <= 32'h0;
            sysen_q <= 1'b0;
        end
        else
        begin
            if (wr_en)
                en_q <= pwdata;
            if (wr_on && paddr[11:0] == 12'h180)
                sysen_q <= pwdata[0];
        end
    end

    a_bus_answer: assert property (pready && !pslverr)
        else $error("bus answer not ready or not okay");
    a_irq_summary: assert property (system_irq |-> time_unit_summary_event)
        else $error("irq without summary event");
    a_irq_enable: assert property (system_irq |-> sysen_q)
        else $error("irq without summary enable");
    a_summary_gated: assert property (time_unit_summary_event |-> en_q != 32'h0)
        else $error("summary event with no enable");
    a_egress_summary: assert property (egress_stamp_stored && en_q[12] && !wr_en
        |=> time_unit_summary_event)
        else $error("enabled egress stamp left summary low");
    a_ingress_summary: assert property (ingress_stamp_stored && en_q[8] && !wr_en
        |=> time_unit_summary_event)
        else $error("enabled ingress stamp left summary low");
    a_manual_summary: assert property (|(manual_capture & en_q[23:16]) && !wr_en
        |=> time_unit_summary_event)
        else $error("enabled manual capture left summary low");
    a_tgt_a_hold: assert property (!wr_on && clock_seconds < tgt_a_seconds_q
        |=> $stable(tgt_a_seconds_q))
        else $error("target a moved before being reached");
    a_tgt_b_hold: assert property (!wr_on && clock_seconds < tgt_b_seconds_q
        |=> $stable(tgt_b_seconds_q))
        else $error("target b moved before being reached");
    a_reserved_zero: assert property (psel && !penable && !pwrite
        && paddr[11:0] == 12'h108 |=> (prdata & 32'h0000eefc) == 32'h0)
        else $error("reserved status bits read nonzero");

    c_irq: cover property ($rose(system_irq));
    c_egress: cover property (egress_stamp_stored && en_q[12]);
    c_tgt_move: cover property (!wr_on && $changed(tgt_a_seconds_q));
endmodule // ptpevt_status_props

/* bench/ptpevt_status_tb.sv */
// bench for the ptp event status block: apb tasks, event pulses, timer reach
// assumes the design at default NGPIO and a single 10 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module ptp_event_interrupt_status_tb_top;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, clk_sec = 32'h0, rd;
    logic [29:0] clk_ns = 30'h0;
    logic [7:0]  cap_gpio = 8'h0, man_cap = 8'h0;
    logic        eg_st = 1'b0, eg_rd = 1'b0, in_st = 1'b0, in_rd = 1'b0;
    wire  [31:0] prdata, ta_s, tb_s;
    wire  [29:0] ta_n, tb_n;
    wire         pready, pslverr, sum_ev, sys_irq;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    logic [11:0] wa [9] = '{12'h148, 12'h14c, 12'h140, 12'h144, 12'h158,
                            12'h15c, 12'h150, 12'h100, 12'h108};
    logic [31:0] wd [9] = '{32'h5, 32'hc8, 32'ha, 32'h3b9ac99c, 32'h3,
                            32'h7, 32'ha, 32'ha02, 32'hffffffff};

    ptpevt_status i_dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_gpio(cap_gpio), .gpio_polarity(8'hff),
        .manual_capture(man_cap), .egress_stamp_stored(eg_st),
        .egress_stamp_read(eg_rd), .ingress_stamp_stored(in_st),
        .ingress_stamp_read(in_rd), .clock_seconds(clk_sec),
        .clock_nanoseconds(clk_ns), .time_unit_summary_event(sum_ev),
        .system_irq(sys_irq), .tgt_a_seconds_q(ta_s), .tgt_a_nanoseconds_q(ta_n),
        .tgt_b_seconds_q(tb_s), .tgt_b_nanoseconds_q(tb_n)
    );

    // 100 ns clock
    always #50 mclk = ~mclk;

    // one apb transfer, held until pready is seen high
    task automatic apb(input bit w, input [11:0] a, input [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input [11:0] a, input [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    // one-cycle stamp event pulses
    task automatic ev(input bit e, input bit i, input bit r);
        @(posedge mclk);
        eg_st <= e;
        in_st <= i;
        eg_rd <= r;
        @(posedge mclk);
        eg_st <= 1'b0;
        in_st <= 1'b0;
        eg_rd <= 1'b0;
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // cuts a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk_rd(12'h10c, 32'h0, "enable");
        chk_rd(12'h180, 32'h0, "sys");
        apb(1'b1, 12'h1f0, 32'hffffffff);
        chk_rd(12'h1f0, 32'h0, "unmapped");
        foreach (wa[k])
            apb(1'b1, wa[k], wd[k]);
        chk_rd(12'h100, 32'ha02, "action");
        chk_rd(12'h108, 32'h0, "cleared");
        done("reset");
        ev(1'b1, 1'b1, 1'b0);
        chk_rd(12'h108, 32'h1100, "stamps");
        `CHK("summary off", 1'b0, sum_ev)
        apb(1'b1, 12'h10c, 32'hffffffff);
        chk_rd(12'h10c, 32'hffff1103, "enable");
        `CHK("summary on", 1'b1, sum_ev)
        `CHK("irq off", 1'b0, sys_irq)
        apb(1'b1, 12'h180, 32'h1);
        #1 `CHK("irq on", 1'b1, sys_irq)
        apb(1'b1, 12'h108, 32'h100);
        chk_rd(12'h108, 32'h1000, "w1c");
        repeat (5) ev(1'b1, 1'b1, 1'b0);
        ev(1'b0, 1'b0, 1'b1);
        chk_rd(12'h184, 32'h34, "counts");
        done("stamps");
        apb(1'b1, 12'h108, 32'hffffffff);
        cap_gpio <= 8'h01;
        repeat (3) @(posedge mclk);
        cap_gpio <= 8'h00;
        man_cap <= 8'h08;
        @(posedge mclk);
        man_cap <= 8'h00;
        repeat (3) @(posedge mclk);
        chk_rd(12'h108, 32'h09090000, "edges");
        done("gpio");
        apb(1'b1, 12'h108, 32'hffffffff);
        clk_sec <= 32'd11;
        repeat (3) @(posedge mclk);
        chk_rd(12'h108, 32'h3, "timers");
        `CHK("tgt a s", 32'd16, ta_s)
        `CHK("tgt a ns", 30'd100, ta_n)
        `CHK("tgt b s", 32'd3, tb_s)
        `CHK("tgt b ns", 30'd7, tb_n)
        cap_gpio <= 8'h04;
        repeat (4) @(posedge mclk);
        chk_rd(12'h108, 32'h00040002, "gpio clear");
        done("timers");
        tally_and_finish();
    end
endmodule // ptp_event_interrupt_status_tb_top

bind ptpevt_status ptpevt_status_props #(.NGPIO(NGPIO)) u_props (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .manual_capture(manual_capture),
    .egress_stamp_stored(egress_stamp_stored),
    .ingress_stamp_stored(ingress_stamp_stored), .clock_seconds(clock_seconds),
    .time_unit_summary_event(time_unit_summary_event), .system_irq(system_irq),
    .tgt_a_seconds_q(tgt_a_seconds_q), .tgt_b_seconds_q(tgt_b_seconds_q)
);
